/* rtl/lcg_pkg.sv */
// Package: register map, field layout and bus constants for the logic cell input gate select
package lcg_pkg;

    // Register byte offsets on the AHB-Lite bus
    localparam logic [31:0] LCG_OFS_SEL0   = 32'h0000_0000;
    localparam logic [31:0] LCG_OFS_SEL1   = 32'h0000_0004;
    localparam logic [31:0] LCG_OFS_SEL2   = 32'h0000_0008;
    localparam logic [31:0] LCG_OFS_SEL3   = 32'h0000_000C;
    localparam logic [31:0] LCG_OFS_GLS0   = 32'h0000_0010;
    localparam logic [31:0] LCG_OFS_POL    = 32'h0000_0014;
    localparam logic [31:0] LCG_OFS_STATUS = 32'h0000_0018;

    // Register index as produced by the address decoder
    localparam logic [2:0] LCG_IDX_SEL0   = 3'h0;
    localparam logic [2:0] LCG_IDX_SEL1   = 3'h1;
    localparam logic [2:0] LCG_IDX_SEL2   = 3'h2;
    localparam logic [2:0] LCG_IDX_SEL3   = 3'h3;
    localparam logic [2:0] LCG_IDX_GLS0   = 3'h4;
    localparam logic [2:0] LCG_IDX_POL    = 3'h5;
    localparam logic [2:0] LCG_IDX_STATUS = 3'h6;
    localparam logic [2:0] LCG_IDX_NONE   = 3'h7;

    // Source selector field
    localparam int          LCG_SEL_W    = 6;
    localparam int          LCG_SEL_LSB  = 0;
    localparam logic [25:0] LCG_SEL_ZERO = 26'h000_0000;

    // Gate 1 term select bit positions
    localparam int LCG_G1_IN4_TRUE = 7;
    localparam int LCG_G1_IN4_INV  = 6;
    localparam int LCG_G1_IN3_TRUE = 5;
    localparam int LCG_G1_IN3_INV  = 4;
    localparam int LCG_G1_IN2_TRUE = 3;
    localparam int LCG_G1_IN2_INV  = 2;
    localparam int LCG_G1_IN1_TRUE = 1;
    localparam int LCG_G1_IN1_INV  = 0;
    localparam int LCG_GLS_W       = 8;

    // Gate polarity register: bit n inverts gate n+1
    localparam int LCG_POL_W         = 4;
    localparam int LCG_POL_GATE1_BIT = 0;
    localparam int LCG_POL_GATE3_BIT = 2;

    // Status register: selected data in bits 3:0, gate outputs in bits 7:4
    localparam int LCG_STAT_DATA_LSB = 0;
    localparam int LCG_STAT_GATE_LSB = 4;

    // Reset value of the bus-side flops
    localparam logic [31:0] LCG_RDATA_RST = 32'h0000_0000;

    // AHB-Lite transfer type and response codes
    localparam logic [1:0] LCG_HTRANS_NONSEQ = 2'h2;
    localparam logic       LCG_HRESP_OKAY    = 1'h0;

    // Data phase state of the bus slave
    typedef enum logic [1:0] {
        LCG_PH_IDLE  = 2'b00,
        LCG_PH_WRITE = 2'b01,
        LCG_PH_READ  = 2'b10
    } lcg_phase_t;

endpackage

/* rtl/lcg_src_mux.sv */
// Source multiplexer: picks one data source by index and registers it
`timescale 1ns/1ns
module lcg_src_mux
    import lcg_pkg::*;
#(
    parameter int NSRC  = 64,
    parameter int SEL_W = 6
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [NSRC-1:0]  i_src,
    input  wire logic [SEL_W-1:0] i_sel,
    output logic                  o_data
);

    initial begin
        if (NSRC < 1 || NSRC > (1 << SEL_W)) begin
            $error("lcg_src_mux: NSRC must lie between 1 and 2**SEL_W");
        end
    end

    // Indices past the last source read as low
    wire logic in_range;
    wire logic data_next;

    assign in_range  = (32'(i_sel) < NSRC);
    assign data_next = in_range ? i_src[i_sel] : 1'b0;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data <= 1'b0;
        end else begin
            o_data <= data_next;
        end
    end

endmodule

/* rtl/lcg_top.sv */
// Logic cell input selection and gate 1 term selection with AHB-Lite registers
//
// Functional notes
// - data 1 input source is chosen by the 6-bit field of select register 0
// - data 2 input source is chosen by the 6-bit field of select register 1
// - data 3 input source is chosen by the 6-bit field of select register 2
// - data 4 input source is chosen by the 6-bit field of select register 3
// - select register bits 7-6 read zero and ignore writes
// - select and gate registers unknown at power-up, kept across reset
// - gate 1 bit 7 adds true data 4, bit 6 adds inverted data 4
// - gate 1 bit 5 adds true data 3, bit 4 adds inverted data 3
// - gate 1 bit 3 adds true data 2, bit 2 adds inverted data 2
// - gate 1 bit 1 adds true data 1, bit 0 adds inverted data 1
// - a set gate polarity bit inverts that gate's output
`timescale 1ns/1ns
module lcg_top
    import lcg_pkg::*;
#(
    parameter int NSRC = 64
) (
    input  wire logic            i_clk,
    input  wire logic            i_rstn,
    input  wire logic            i_hsel,
    input  wire logic [31:0]     i_haddr,
    input  wire logic [1:0]      i_htrans,
    input  wire logic            i_hwrite,
    input  wire logic [2:0]      i_hsize,
    input  wire logic [31:0]     i_hwdata,
    input  wire logic            i_hready,
    output logic                 o_hreadyout,
    output logic                 o_hresp,
    output logic [31:0]          o_hrdata,
    input  wire logic [NSRC-1:0] i_src,
    input  wire logic [2:0]      i_gate_raw,
    output logic [3:0]           o_data,
    output logic [3:0]           o_gate_out
);

    initial begin
        if (NSRC < 1 || NSRC > (1 << LCG_SEL_W)) begin
            $error("lcg_top: NSRC must lie between 1 and 64");
        end
    end

    // Register index of a bus address; unmapped addresses give the none index
    function automatic logic [2:0] reg_index(input logic [31:0] addr);
        logic [2:0] idx;
        idx = LCG_IDX_NONE;
        if (addr == LCG_OFS_SEL0) begin
            idx = LCG_IDX_SEL0;
        end else if (addr == LCG_OFS_SEL1) begin
            idx = LCG_IDX_SEL1;
        end else if (addr == LCG_OFS_SEL2) begin
            idx = LCG_IDX_SEL2;
        end else if (addr == LCG_OFS_SEL3) begin
            idx = LCG_IDX_SEL3;
        end else if (addr == LCG_OFS_GLS0) begin
            idx = LCG_IDX_GLS0;
        end else if (addr == LCG_OFS_POL) begin
            idx = LCG_IDX_POL;
        end else if (addr == LCG_OFS_STATUS) begin
            idx = LCG_IDX_STATUS;
        end
        return idx;
    endfunction

    // Selector value placed in a bus word with the unimplemented bits at zero
    function automatic logic [31:0] sel_word(input logic [LCG_SEL_W-1:0] sel);
        return {LCG_SEL_ZERO, sel};
    endfunction

    // ------------------------------------------------------------------
    // Bus slave: address phase captured, write done in the data phase
    // ------------------------------------------------------------------
    lcg_phase_t      phase_reg;
    lcg_phase_t      phase_next;
    logic [2:0]      widx_reg;
    logic [31:0]     rdata_reg;

    wire logic       addr_valid;
    wire logic [2:0] aidx;
    wire logic       wr_active;
    wire logic [2:0] widx;

    assign addr_valid = i_hsel && i_hready && (i_htrans == LCG_HTRANS_NONSEQ);
    assign aidx       = reg_index(i_haddr);
    assign phase_next = !addr_valid ? LCG_PH_IDLE :
                        (i_hwrite ? LCG_PH_WRITE : LCG_PH_READ);
    assign wr_active  = (phase_reg == LCG_PH_WRITE);
    assign widx       = wr_active ? widx_reg : LCG_IDX_NONE;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg <= LCG_PH_IDLE;
            widx_reg  <= LCG_IDX_NONE;
        end else begin
            phase_reg <= phase_next;
            widx_reg  <= aidx;
        end
    end

    // Zero wait states and always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp     = LCG_HRESP_OKAY;

    // ------------------------------------------------------------------
    // Configuration registers: no reset so their contents survive i_rstn
    // ------------------------------------------------------------------
    logic [LCG_SEL_W-1:0] sel_reg [4];
    logic [LCG_SEL_W-1:0] sel_next [4];
    logic [LCG_GLS_W-1:0] gls_reg;
    logic [LCG_GLS_W-1:0] gls_next;
    logic [LCG_POL_W-1:0] pol_reg;
    logic [LCG_POL_W-1:0] pol_next;

    // Only the low six bits of a selector write are kept
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sel
            assign sel_next[gi] = (widx == 3'(gi)) ?
                                  i_hwdata[LCG_SEL_LSB +: LCG_SEL_W] : sel_reg[gi];
            always_ff @(posedge i_clk) begin
                sel_reg[gi] <= sel_next[gi];
            end
        end
    endgenerate

    assign gls_next = (widx == LCG_IDX_GLS0) ? i_hwdata[LCG_GLS_W-1:0] : gls_reg;
    assign pol_next = (widx == LCG_IDX_POL) ? i_hwdata[LCG_POL_W-1:0] : pol_reg;

    always_ff @(posedge i_clk) begin
        gls_reg <= gls_next;
        pol_reg <= pol_next;
    end

    // Check helper: marks registers written since reset, so that checks skip power-up unknowns
    logic [5:0]      seen_reg;
    wire logic [5:0] seen_set;

    assign seen_set = wr_active ? (6'h01 << widx_reg) : 6'h00;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            seen_reg <= 6'h00;
        end else begin
            seen_reg <= seen_reg | seen_set;
        end
    end

    // ------------------------------------------------------------------
    // Input selection
    // ------------------------------------------------------------------
    // One multiplexer per data input, each steered by its own selector
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mux
            lcg_src_mux #(
                .NSRC  (NSRC),
                .SEL_W (LCG_SEL_W)
            ) u_mux (
                .i_clk  (i_clk),
                .i_rstn (i_rstn),
                .i_src  (i_src),
                .i_sel  (sel_reg[gi]),
                .o_data (o_data[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Gate 1 term selection and gate polarity
    // ------------------------------------------------------------------
    wire logic [LCG_GLS_W-1:0] g1_terms;
    wire logic [LCG_GLS_W-1:0] g1_enabled;
    wire logic                 g1_raw;
    wire logic [3:0]           gate_raw;
    wire logic [3:0]           gate_next;

    assign g1_terms[LCG_G1_IN4_TRUE] = o_data[3];
    assign g1_terms[LCG_G1_IN4_INV]  = ~o_data[3];
    assign g1_terms[LCG_G1_IN3_TRUE] = o_data[2];
    assign g1_terms[LCG_G1_IN3_INV]  = ~o_data[2];
    assign g1_terms[LCG_G1_IN2_TRUE] = o_data[1];
    assign g1_terms[LCG_G1_IN2_INV]  = ~o_data[1];
    assign g1_terms[LCG_G1_IN1_TRUE] = o_data[0];
    assign g1_terms[LCG_G1_IN1_INV]  = ~o_data[0];

    // Cleared enables drop their term; no term leaves the gate low
    assign g1_enabled = g1_terms & gls_reg;
    assign g1_raw     = |g1_enabled;
    assign gate_raw   = {i_gate_raw, g1_raw};
    assign gate_next  = gate_raw ^ pol_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_gate_out <= 4'h0;
        end else begin
            o_gate_out <= gate_next;
        end
    end

    // ------------------------------------------------------------------
    // Read data: taken from next values so a write just before is seen
    // ------------------------------------------------------------------
    wire logic [31:0] status_word;
    wire logic [31:0] rdata_next;

    assign status_word = {24'h00_0000, o_gate_out, o_data};

    assign rdata_next =
        !(addr_valid && !i_hwrite) ? LCG_RDATA_RST :
        (aidx == LCG_IDX_SEL0)   ? sel_word(sel_next[0]) :
        (aidx == LCG_IDX_SEL1)   ? sel_word(sel_next[1]) :
        (aidx == LCG_IDX_SEL2)   ? sel_word(sel_next[2]) :
        (aidx == LCG_IDX_SEL3)   ? sel_word(sel_next[3]) :
        (aidx == LCG_IDX_GLS0)   ? {24'h00_0000, gls_next} :
        (aidx == LCG_IDX_POL)    ? {28'h000_0000, pol_next} :
        (aidx == LCG_IDX_STATUS) ? status_word : LCG_RDATA_RST;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= LCG_RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_hrdata = rdata_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_addr_wr(logic [31:0] ofs);
        i_hsel && i_hready && i_htrans == LCG_HTRANS_NONSEQ && i_hwrite && i_haddr == ofs;
    endsequence

    sequence s_addr_rd(logic [31:0] ofs);
        i_hsel && i_hready && i_htrans == LCG_HTRANS_NONSEQ && !i_hwrite && i_haddr == ofs;
    endsequence

    // Selector steadiness for two cycles lets the mux output be compared
    sequence s_sel_steady(int n);
        seen_reg[n] && $stable(sel_reg[n]) ##1 $stable(sel_reg[n]);
    endsequence

    chk_d1_route: assert property (
        s_sel_steady(0) |-> o_data[0] ==
            ((32'(sel_reg[0]) < NSRC) ? $past(i_src[sel_reg[0]]) : 1'b0))
        else $error("data 1 does not follow its selected source");

    chk_d2_route: assert property (
        s_sel_steady(1) |-> o_data[1] ==
            ((32'(sel_reg[1]) < NSRC) ? $past(i_src[sel_reg[1]]) : 1'b0))
        else $error("data 2 does not follow its selected source");

    chk_d3_route: assert property (
        s_sel_steady(2) |-> o_data[2] ==
            ((32'(sel_reg[2]) < NSRC) ? $past(i_src[sel_reg[2]]) : 1'b0))
        else $error("data 3 does not follow its selected source");

    chk_d4_route: assert property (
        s_sel_steady(3) |-> o_data[3] ==
            ((32'(sel_reg[3]) < NSRC) ? $past(i_src[sel_reg[3]]) : 1'b0))
        else $error("data 4 does not follow its selected source");

    chk_sel_write_kept: assert property (
        s_addr_wr(LCG_OFS_SEL0) |=> ##1 sel_reg[0] == $past(i_hwdata[5:0]))
        else $error("selector 0 did not take the written field");

    chk_sel_upper_zero: assert property (
        (s_addr_rd(LCG_OFS_SEL0) or s_addr_rd(LCG_OFS_SEL3)) |=> o_hrdata[31:6] == 26'h0)
        else $error("selector read shows bits above the field");

    chk_cfg_kept_idle: assert property (
        !wr_active |=> $stable(gls_reg) && $stable(pol_reg))
        else $error("configuration changed without a write");

    chk_g1_in4_terms: assert property (
        (gls_reg[7] && o_data[3] || gls_reg[6] && !o_data[3]) && !pol_reg[0]
            |=> o_gate_out[0])
        else $error("gate 1 missed an enabled data 4 term");

    chk_g1_in3_terms: assert property (
        (gls_reg[5] && o_data[2] || gls_reg[4] && !o_data[2]) && !pol_reg[0]
            |=> o_gate_out[0])
        else $error("gate 1 missed an enabled data 3 term");

    chk_g1_in2_terms: assert property (
        (gls_reg[3] && o_data[1] || gls_reg[2] && !o_data[1]) && !pol_reg[0]
            |=> o_gate_out[0])
        else $error("gate 1 missed an enabled data 2 term");

    chk_g1_in1_terms: assert property (
        (gls_reg[1] && o_data[0] || gls_reg[0] && !o_data[0]) && !pol_reg[0]
            |=> o_gate_out[0])
        else $error("gate 1 missed an enabled data 1 term");

    chk_gate_polarity: assert property (
        seen_reg[LCG_IDX_POL] |=> o_gate_out[3:1] == ($past(i_gate_raw) ^ $past(pol_reg[3:1])))
        else $error("gate polarity not applied to gates 2 to 4");

    chk_g1_empty_low: assert property (
        gls_reg == 8'h00 && seen_reg[LCG_IDX_POL] |=> o_gate_out[0] == $past(pol_reg[0]))
        else $error("gate 1 not low with no term enabled");

endmodule

/* verif/lcg_top_tb.sv */
// Self-checking bench for the logic cell input selection and gate 1 term selection
`timescale 1ns/1ns
module lcg_top_tb
    import lcg_pkg::*;
;
    localparam int NSRC = 64;

    logic            clk;
    logic            rst_n;
    logic            hsel;
    logic [31:0]     haddr;
    logic [1:0]      htrans;
    logic            hwrite;
    logic [2:0]      hsize;
    logic [31:0]     hwdata;
    logic            hreadyout;
    logic            hresp;
    logic [31:0]     hrdata;
    logic [NSRC-1:0] src;
    logic [NSRC-1:0] pat;
    logic [2:0]      gate_raw;
    logic [3:0]      data_out;
    logic [3:0]      gate_out;
    int              bad_count;
    int              check_count;
    logic [5:0]      sel [4];
    logic [31:0]     sel_ofs [4];
    logic [5:0]      idx_tab [8];
    logic [7:0]      gls_tab [11];
    logic [3:0]      pol_tab [3];
    logic [3:0]      exp_data;
    logic [3:0]      pol;

    lcg_top #(
        .NSRC (NSRC)
    ) DUT (
        .i_clk       (clk),
        .i_rstn      (rst_n),
        .i_hsel      (hsel),
        .i_haddr     (haddr),
        .i_htrans    (htrans),
        .i_hwrite    (hwrite),
        .i_hsize     (hsize),
        .i_hwdata    (hwdata),
        .i_hready    (hreadyout),
        .o_hreadyout (hreadyout),
        .o_hresp     (hresp),
        .o_hrdata    (hrdata),
        .i_src       (src),
        .i_gate_raw  (gate_raw),
        .o_data      (data_out),
        .o_gate_out  (gate_out)
    );

    always #5 clk = ~clk;

    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check4(input string name, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One single AHB-Lite transfer; read data taken at the edge ending the data phase
    task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= LCG_HTRANS_NONSEQ;
        haddr  <= addr;
        hwrite <= wr;
        @(posedge clk iff hreadyout === 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wdata : 32'h0000_0000;
        @(posedge clk iff hreadyout === 1'b1);
        rdata = hrdata;
    endtask

    task automatic wr_reg(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        ahb_xfer(1'b1, addr, data, unused);
    endtask

    task automatic rd_check(input logic [31:0] addr, input logic [31:0] exp, input string name);
        logic [31:0] got;
        ahb_xfer(1'b0, addr, 32'h0000_0000, got);
        check32(name, exp, got);
    endtask

    // Data needs one edge and the gate one more, so three edges leave both settled
    task automatic check_ports(input logic [3:0] exp_d, input logic [3:0] exp_g);
        repeat (3) @(posedge clk);
        check4("data_out", exp_d, data_out);
        check4("gate_out", exp_g, gate_out);
    endtask

    function automatic logic g1_of(input logic [7:0] g, input logic [3:0] d);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = r | (g[2*i+1] & d[i]) | (g[2*i] & ~d[i]);
        end
        return r;
    endfunction

    initial begin
        clk         = 1'b0;
        rst_n       = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0000_0000;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hsize       = 3'b010;
        hwdata      = 32'h0000_0000;
        src         = '0;
        gate_raw    = 3'b011;
        bad_count   = 0;
        check_count = 0;
        pat         = 64'hA5C3_0F96_5A3C_F069;
        sel_ofs     = '{LCG_OFS_SEL0, LCG_OFS_SEL1, LCG_OFS_SEL2, LCG_OFS_SEL3};
        idx_tab     = '{6'h00, 6'h3F, 6'h01, 6'h3E, 6'h15, 6'h2A, 6'h20, 6'h1F};
        gls_tab     = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                        8'h96, 8'hFF};
        pol_tab     = '{4'hF, 4'h5, 4'hA};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Selector width and unimplemented top bits
        for (int n = 0; n < 4; n++) begin
            wr_reg(sel_ofs[n], 32'hFFFF_FFFF);
            rd_check(sel_ofs[n], 32'h0000_003F, "sel_full");
            wr_reg(sel_ofs[n], 32'h0000_00C0 | 32'(n + 60));
            rd_check(sel_ofs[n], 32'(n + 60), "sel_low");
        end
        wr_reg(LCG_OFS_GLS0, 32'h0000_0000);
        wr_reg(LCG_OFS_POL, 32'h0000_0000);
        // Source routing over boundary indices, both source polarities
        for (int t = 0; t < 8; t++) begin
            for (int n = 0; n < 4; n++) begin
                sel[n] = idx_tab[(t + n) % 8];
                wr_reg(sel_ofs[n], {26'h000_0000, sel[n]});
            end
            for (int v = 0; v < 2; v++) begin
                src <= v ? ~pat : pat;
                for (int n = 0; n < 4; n++) begin
                    exp_data[n] = v ? ~pat[sel[n]] : pat[sel[n]];
                end
                check_ports(exp_data, {gate_raw, 1'b0});
            end
        end
        // Gate 1 terms over every single enable and every data pattern
        for (int n = 0; n < 4; n++) begin
            wr_reg(sel_ofs[n], 32'(n));
        end
        for (int g = 0; g < 11; g++) begin
            wr_reg(LCG_OFS_GLS0, {24'h00_0000, gls_tab[g]});
            rd_check(LCG_OFS_GLS0, {24'h00_0000, gls_tab[g]}, "gls");
            for (int d = 0; d < 16; d++) begin
                src <= NSRC'(d);
                check_ports(4'(d), {gate_raw, g1_of(gls_tab[g], 4'(d))});
            end
        end
        // Gate polarity
        wr_reg(LCG_OFS_GLS0, 32'h0000_0002);
        for (int p = 0; p < 3; p++) begin
            pol = pol_tab[p];
            wr_reg(LCG_OFS_POL, {28'h000_0000, pol});
            rd_check(LCG_OFS_POL, {28'h000_0000, pol}, "pol");
            for (int d = 0; d < 2; d++) begin
                gate_raw <= d ? 3'b101 : 3'b010;
                src      <= NSRC'(d);
                check_ports(4'(d), {(d ? 3'b101 : 3'b010) ^ pol[3:1], 1'(d) ^ pol[0]});
            end
        end
        // Status shows the last data and gate levels: data 4'h1, gates 4'h1
        rd_check(LCG_OFS_STATUS, 32'h0000_0011, "status");
        check4("hresp", 4'h0, {3'b000, hresp});
        // Unmapped address reads zero and a write there changes nothing
        wr_reg(32'h0000_0020, 32'hFFFF_FFFF);
        rd_check(32'h0000_0020, 32'h0000_0000, "unmapped");
        // Configuration survives a reset in mid-run
        wr_reg(LCG_OFS_GLS0, 32'h0000_005A);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            rd_check(sel_ofs[n], 32'(n), "sel_kept");
        end
        rd_check(LCG_OFS_GLS0, 32'h0000_005A, "gls_kept");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule
